// ### inc/tcp_regs.svh
`ifndef TCP_REGS_SVH
`define TCP_REGS_SVH
// timing figures as printed, cycle counts derived at 50 MHz
`define TCP_CLK_MHZ          50
`define TCP_CLK_PERIOD_PS    20000
`define TCP_LOW_MIN_PS       4000
`define TCP_HIGH_MIN_PS      40000
`define TCP_FIRE_DELAY_US    35
`define TCP_TXTRIG_US        50
// least times round up, none below one cycle
`define TCP_LOW_MIN_CYC  ((`TCP_LOW_MIN_PS + `TCP_CLK_PERIOD_PS - 1) / `TCP_CLK_PERIOD_PS)
`define TCP_HIGH_MIN_CYC ((`TCP_HIGH_MIN_PS + `TCP_CLK_PERIOD_PS - 1) / `TCP_CLK_PERIOD_PS)
`define TCP_FIRE_CYC     (`TCP_FIRE_DELAY_US * `TCP_CLK_MHZ)
`define TCP_TXTRIG_CYC   (`TCP_TXTRIG_US * `TCP_CLK_MHZ)
// alarm selector codes
`define TCP_SEL_OFF      3'h0
`define TCP_SEL_GATE1    3'h1
`define TCP_SEL_GATE2    3'h2
`define TCP_SEL_IFGATE   3'h3
`define TCP_SEL_HIGHLIM  3'h4
`define TCP_SEL_LOWLIM   3'h5
// alarm mode codes
`define TCP_MODE_T025    3'h0
`define TCP_MODE_T05     3'h1
`define TCP_MODE_T1      3'h2
`define TCP_MODE_T2      3'h3
`define TCP_MODE_INST    3'h4
`define TCP_MODE_LATCH   3'h5
// hold times of timed modes, in ms
`define TCP_HOLD025_MS   250
`define TCP_HOLD05_MS    500
`define TCP_HOLD1_MS     1000
`define TCP_HOLD2_MS     2000
`define TCP_CYC_PER_MS   (`TCP_CLK_MHZ * 1000)
`endif

// ### inc/tcp_pkg.sv
package tcp_pkg;
  typedef enum logic [1:0] {TCP_IDLE, TCP_TRIG, TCP_PROC} tcp_cycle_t;
  typedef enum logic {TCP_SRC_INTERNAL, TCP_SRC_EXTERNAL} tcp_rep_t;
  typedef enum logic {TCP_PULSER_OTHER, TCP_PULSER_SPIKE} tcp_pulser_t;
endpackage : tcp_pkg

// ### core/tcp_scaler.sv
`timescale 1ns/1ps
`include "tcp_regs.svh"
// one analog channel: amplitude or thickness scaled to full-scale code
module tcp_scaler #(
  parameter int W = 12
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         load,
  input  wire logic         isThickness,
  input  wire logic [W-1:0] amplitude,
  input  wire logic [W-1:0] amplitudeFull,
  input  wire logic [W-1:0] thickness,
  input  wire logic [W-1:0] displayStart,
  input  wire logic [W-1:0] displayRange,
  output logic      [W-1:0] code
);
  localparam logic [W-1:0] FULL = {W{1'b1}};

  // value/span scaled to full scale, clipped at full scale
  function automatic logic [W-1:0] scale(input logic [W-1:0] v, input logic [W-1:0] span);
    logic [2*W-1:0] prod;
    logic [2*W-1:0] q;
    prod = v * FULL;
    q    = (span == '0) ? '0 : prod / span;
    scale = (q > {{W{1'b0}}, FULL}) ? FULL : q[W-1:0];
  endfunction : scale

  // update only at the valid instant so the pin is stable between cycles
  always_ff @(posedge clk)
  begin
    if (reset)
      code <= '0;
    else if (load)
    begin
      if (isThickness)
        code <= (thickness <= displayStart) ? '0
              : scale(thickness - displayStart, displayRange);
      else
        code <= scale(amplitude, amplitudeFull);
    end
  end
endmodule : tcp_scaler

// ### core/test_cycle_io_port.sv
`timescale 1ns/1ps
`include "tcp_regs.svh"
// Overview of operation
// - external trigger only with spike, external source
// - qualified edge starts cycle, pulse 35 us later
// - trigger needs 4 ns low, 40 ns high
// - release rising edge activates the alarm, data valid and analog outputs
// - acknowledge edge clears alarms in latched mode
// - analog outputs proportional to selected reading
// - amplitude 100 percent maps to full scale
// - thickness scaled between display delay and range
// - data valid high processing, fall means valid
// - switching outputs high while alarm active
// - transmitter trigger 50 us, pulse 35 us on
// - per-output alarm selector codes 0 to 5
module test_cycle_io_port #(
  parameter int W        = 12,
  parameter int CH       = 4,
  parameter int FIRE_CYC = `TCP_FIRE_CYC,
  parameter int TRIG_CYC = `TCP_TXTRIG_CYC,
  parameter int MS_CYC   = `TCP_CYC_PER_MS
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              external_cycle_trigger,
  input  wire logic              output_release_strobe,
  input  wire logic              alarm_acknowledge_strobe,
  input  wire logic              channel_sync_in,
  input  wire logic              pulserSpike,
  input  wire logic              repetition_source_setting,
  input  wire logic              internalCycleStart,
  input  wire logic              resultsDone,
  input  wire logic [2:0]        alarmMode,
  input  wire logic [8:0]        alarmSelect,
  input  wire logic [4:0]        alarmSources,
  input  wire logic [CH-1:0]     analogIsThickness,
  input  wire logic [CH*W-1:0]   amplitudes,
  input  wire logic [W-1:0]      amplitudeFull,
  input  wire logic [CH*W-1:0]   thicknesses,
  input  wire logic [W-1:0]      displayStart,
  input  wire logic [W-1:0]      displayRange,
  output logic                   transmitter_trigger_out,
  output logic                   pulserFire,
  output logic                   dataValid,
  output logic [2:0]             switchOut,
  output logic [CH*W-1:0]        analogOut,
  output logic                   channelSync,
  output logic                   outputsEnabled
);
  localparam int CW = $clog2(TRIG_CYC + 1) + 1;
  localparam int LOW_CYC  = (`TCP_LOW_MIN_CYC  < 1) ? 1 : `TCP_LOW_MIN_CYC;
  localparam int HIGH_CYC = (`TCP_HIGH_MIN_CYC < 1) ? 1 : `TCP_HIGH_MIN_CYC;

  // two-flop synchronisers for every pin input
  logic [3:0] syncA_reg;
  logic [3:0] syncB_reg;
  logic [3:0] prev_reg;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      syncA_reg <= 4'h0;
      syncB_reg <= 4'h0;
      prev_reg  <= 4'h0;
    end
    else
    begin
      syncA_reg <= {channel_sync_in, alarm_acknowledge_strobe,
                    output_release_strobe, external_cycle_trigger};
      syncB_reg <= syncA_reg;
      prev_reg  <= syncB_reg;
    end
  end
  wire trigIn  = syncB_reg[0];
  wire relRise = syncB_reg[1] & ~prev_reg[1];
  wire ackRise = syncB_reg[2] & ~prev_reg[2];

  // record the multiplexer channel indication
  always_ff @(posedge clk)
  begin
    if (reset)
      channelSync <= 1'b0;
    else
      channelSync <= syncB_reg[3];
  end

  // trigger width filter; short pulses never qualify
  logic [7:0] lowCnt_reg;
  logic [7:0] highCnt_reg;
  logic       armed_reg;
  logic       trigQual;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lowCnt_reg  <= 8'h00;
      highCnt_reg <= 8'h00;
      armed_reg   <= 1'b0;
    end
    else if (!trigIn)
    begin
      highCnt_reg <= 8'h00;
      if (lowCnt_reg < 8'(LOW_CYC))
        lowCnt_reg <= lowCnt_reg + 8'h01;
      armed_reg <= (lowCnt_reg + 8'h01 >= 8'(LOW_CYC));
    end
    else
    begin
      lowCnt_reg <= 8'h00;
      if (highCnt_reg < 8'hff)
        highCnt_reg <= highCnt_reg + 8'h01;
      if (trigQual)
        armed_reg <= 1'b0;
    end
  end
  // fires once per edge, after the high time has been met
  assign trigQual = trigIn & armed_reg & (highCnt_reg + 8'h01 >= 8'(HIGH_CYC));

  // cycle start source selection
  wire extMode    = pulserSpike & repetition_source_setting;
  wire cycleStart = extMode ? trigQual : internalCycleStart;

  // transmitter trigger window and first pulse timing
  tcp_pkg::tcp_cycle_t state_reg;
  logic [CW-1:0]       cnt_reg;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg               <= tcp_pkg::TCP_IDLE;
      cnt_reg                 <= '0;
      transmitter_trigger_out <= 1'b0;
      pulserFire              <= 1'b0;
    end
    else
    begin
      pulserFire <= 1'b0;
      unique case (state_reg)
        tcp_pkg::TCP_IDLE, tcp_pkg::TCP_PROC:
          if (cycleStart)
          begin
            state_reg               <= tcp_pkg::TCP_TRIG;
            cnt_reg                 <= '0;
            transmitter_trigger_out <= 1'b1;
          end
        tcp_pkg::TCP_TRIG:
        begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CW'(FIRE_CYC - 1))
            pulserFire <= 1'b1;
          if (cnt_reg == CW'(TRIG_CYC - 1))
          begin
            transmitter_trigger_out <= 1'b0;
            state_reg               <= tcp_pkg::TCP_PROC;
          end
        end
      endcase
    end
  end
  // a new start during the window is ignored: the trigger window must end first

  // release latch gates every result output
  always_ff @(posedge clk)
  begin
    if (reset)
      outputsEnabled <= 1'b0;
    else if (relRise)
      outputsEnabled <= 1'b1;
  end

  // data valid: high from cycle start until results are done
  logic validLoad;
  always_ff @(posedge clk)
  begin
    if (reset || !outputsEnabled)
      dataValid <= 1'b0;
    else if (cycleStart && state_reg != tcp_pkg::TCP_TRIG) // refused starts leave the flag alone
      dataValid <= 1'b1;
    else if (resultsDone && dataValid)
      dataValid <= 1'b0;
  end
  assign validLoad = outputsEnabled & resultsDone & dataValid;

  // per-output alarm source and hold time
  function automatic logic pickAlarm(input logic [2:0] sel, input logic [4:0] src);
    unique case (sel)
      `TCP_SEL_GATE1:   pickAlarm = src[0];
      `TCP_SEL_GATE2:   pickAlarm = src[1];
      `TCP_SEL_IFGATE:  pickAlarm = src[2];
      `TCP_SEL_HIGHLIM: pickAlarm = src[3];
      `TCP_SEL_LOWLIM:  pickAlarm = src[4];
      default:          pickAlarm = 1'b0; // off and unused codes
    endcase
  endfunction : pickAlarm

  logic [31:0] holdCyc;
  always_comb
  begin
    unique case (alarmMode)
      `TCP_MODE_T025: holdCyc = 32'(`TCP_HOLD025_MS * MS_CYC);
      `TCP_MODE_T05:  holdCyc = 32'(`TCP_HOLD05_MS * MS_CYC);
      `TCP_MODE_T1:   holdCyc = 32'(`TCP_HOLD1_MS * MS_CYC);
      `TCP_MODE_T2:   holdCyc = 32'(`TCP_HOLD2_MS * MS_CYC);
      default:        holdCyc = 32'h0;
    endcase
  end

  logic [31:0] hold_reg [3];
  for (genvar i = 0; i < 3; i++)
  begin : g_alarm
    wire act = pickAlarm(alarmSelect[3*i +: 3], alarmSources);
    always_ff @(posedge clk)
    begin
      if (reset || !outputsEnabled)
      begin
        switchOut[i] <= 1'b0;
        hold_reg[i]  <= 32'h0;
      end
      else if (alarmMode == `TCP_MODE_LATCH)
      begin
        // a new alarm wins over a simultaneous acknowledge
        if (act)
          switchOut[i] <= 1'b1;
        else if (ackRise)
          switchOut[i] <= 1'b0;
      end
      else if (alarmMode == `TCP_MODE_INST)
        switchOut[i] <= act;
      else if (act)
      begin
        switchOut[i] <= 1'b1;
        hold_reg[i]  <= holdCyc;
      end
      else if (hold_reg[i] > 32'h1)
        hold_reg[i] <= hold_reg[i] - 32'h1;
      else
      begin
        hold_reg[i]  <= 32'h0;
        switchOut[i] <= 1'b0;
      end
    end
  end

  // analog channels refresh at the valid instant
  for (genvar c = 0; c < CH; c++)
  begin : g_analog
    tcp_scaler #(.W(W)) u_scale (
      .clk          (clk),
      .reset        (reset),
      .load         (validLoad),
      .isThickness  (analogIsThickness[c]),
      .amplitude    (amplitudes[c*W +: W]),
      .amplitudeFull(amplitudeFull),
      .thickness    (thicknesses[c*W +: W]),
      .displayStart (displayStart),
      .displayRange (displayRange),
      .code         (analogOut[c*W +: W])
    );
  end
endmodule : test_cycle_io_port

// ### verif/tcp_io_properties.sv
`timescale 1ns/1ps
module tcp_io_properties #(
  parameter int W        = 12,
  parameter int CH       = 4,
  parameter int FIRE_CYC = 20,
  parameter int TRIG_CYC = 40
) (
  input wire logic            clk,
  input wire logic            reset,
  input wire logic            pulserSpike,
  input wire logic            repetition_source_setting,
  input wire logic            internalCycleStart,
  input wire logic            resultsDone,
  input wire logic [2:0]      alarmMode,
  input wire logic [8:0]      alarmSelect,
  input wire logic [4:0]      alarmSources,
  input wire logic            transmitter_trigger_out,
  input wire logic            pulserFire,
  input wire logic            dataValid,
  input wire logic [2:0]      switchOut,
  input wire logic [CH*W-1:0] analogOut,
  input wire logic            outputsEnabled
);
  localparam int TRIG_LAST = TRIG_CYC - 1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // trigger timing seen from its own rising edge
  fire_delay_a: assert property (
    $rose(transmitter_trigger_out) |-> ##FIRE_CYC pulserFire) else $error("fire late");
  fire_single_a: assert property (
    pulserFire |=> !pulserFire) else $error("fire too long");
  trig_width_a: assert property (
    $rose(transmitter_trigger_out) |-> ##TRIG_LAST transmitter_trigger_out ##1
    !transmitter_trigger_out) else $error("trigger width wrong");
  // no alarm, data valid or analog output may leak before the release strobe
  hold_quiet_a: assert property (
    !outputsEnabled |-> (switchOut == 3'h0 && !dataValid && analogOut == '0))
    else $error("output active before release");
  valid_start_a: assert property (
    $rose(transmitter_trigger_out) && outputsEnabled |-> dataValid) else $error("valid low");
  valid_end_a: assert property (
    resultsDone && dataValid |=> !dataValid) else $error("valid stuck");
  // outside spike plus external only the internal start may open a cycle
  source_gate_a: assert property (
    $rose(transmitter_trigger_out) && !($past(pulserSpike) && $past(repetition_source_setting))
    |-> $past(internalCycleStart)) else $error("cycle from ignored trigger");
  inst_alarm_a: assert property (
    outputsEnabled && alarmMode == 3'h4 && alarmSelect[2:0] == 3'h1
    |=> switchOut[0] == $past(alarmSources[0])) else $error("alarm not mirrored");
endmodule : tcp_io_properties
bind test_cycle_io_port tcp_io_properties #(.W(W), .CH(CH), .FIRE_CYC(FIRE_CYC),
  .TRIG_CYC(TRIG_CYC)) tcp_io_properties_inst (.clk(clk), .reset(reset),
  .pulserSpike(pulserSpike), .repetition_source_setting(repetition_source_setting),
  .internalCycleStart(internalCycleStart), .resultsDone(resultsDone), .alarmMode(alarmMode),
  .alarmSelect(alarmSelect), .alarmSources(alarmSources),
  .transmitter_trigger_out(transmitter_trigger_out), .pulserFire(pulserFire),
  .dataValid(dataValid), .switchOut(switchOut), .analogOut(analogOut),
  .outputsEnabled(outputsEnabled));

// ### verif/tcp_far_end.sv
`timescale 1ns/1ps
module tcp_far_end (
  input  wire logic       clk,
  input  wire logic [2:0] req,
  input  wire logic [3:0] width,
  output logic      [2:0] pins
);
  logic [2:0] sel_reg = 3'h0;
  logic [3:0] cnt_reg = 4'h0;
  // one strobe at a time; pins idle low, so a low phase always precedes each rise
  always_ff @(posedge clk)
  begin
    if (req != 3'h0)
    begin
      sel_reg <= req;
      cnt_reg <= width;
    end
    else if (cnt_reg != 4'h0)
      cnt_reg <= cnt_reg - 4'h1;
  end
  assign pins = (cnt_reg != 4'h0) ? sel_reg : 3'h0;
endmodule : tcp_far_end

// ### verif/test_test_cycle_io_port.sv
`timescale 1ns/1ps
module test_test_cycle_io_port;
  localparam int FC = 20;
  localparam int TC = 40;
  logic clk = 1'b0, reset = 1'b1, spike = 1'b0, extSrc = 1'b0, intStart = 1'b0;
  logic done = 1'b0, syncIn = 1'b0, isThk = 1'b0, tto, fire, dv, cs, oe;
  logic [2:0] mode = 3'h4, req = 3'h0, sw, pins;
  logic [3:0] width = 4'h3;
  logic [8:0] sel = 9'h0;
  logic [4:0] src = 5'h0;
  logic [11:0] amp = 12'h100, thk = 12'h010, dStart = 12'h100, ao;
  int n_fail = 0, n_compared = 0, k, c;
  tcp_far_end tcp_far_end_inst (.clk(clk), .req(req), .width(width), .pins(pins));
  test_cycle_io_port #(.W(12), .CH(1), .FIRE_CYC(FC), .TRIG_CYC(TC), .MS_CYC(10))
    test_cycle_io_port_inst (.clk(clk), .reset(reset), .external_cycle_trigger(pins[0]),
    .output_release_strobe(pins[1]), .alarm_acknowledge_strobe(pins[2]),
    .channel_sync_in(syncIn), .pulserSpike(spike), .repetition_source_setting(extSrc),
    .internalCycleStart(intStart), .resultsDone(done), .alarmMode(mode),
    .alarmSelect(sel), .alarmSources(src), .analogIsThickness(isThk), .amplitudes(amp),
    .amplitudeFull(12'h100), .thicknesses(thk), .displayStart(dStart),
    .displayRange(12'h200), .transmitter_trigger_out(tto), .pulserFire(fire),
    .dataValid(dv), .switchOut(sw), .analogOut(ao), .channelSync(cs),
    .outputsEnabled(oe));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic strobe(input logic [2:0] which, input logic [3:0] w);
    req = which;
    width = w;
    tick(1);
    req = 3'h0;
  endtask : strobe
  // bounded so a dead trigger path cannot hang the run
  task automatic wait_tto;
    c = 0;
    while (tto !== 1'b1 && c < 30)
    begin
      tick(1);
      c++;
    end
  endtask : wait_tto
  task automatic give_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    forever #10 clk = ~clk;
  end
  // the tests need about 3000 cycles, most of them the timed alarm hold
  initial
  begin
    #200us;
    n_fail++;
    give_verdict;
  end
  initial
  begin
    tick(20);
    reset = 1'b0;
    sel = 9'h001;
    src = 5'h01;
    tick(6);
    check(12'(sw), 12'h0);
    strobe(3'h2, 4'h3);
    syncIn = 1'b1;
    tick(5);
    check(12'(oe), 12'h1);
    check(12'(sw), 12'h1);
    check(12'(cs), 12'h1);
    $display("release test done");
    // each selector code 1 to 5 picks exactly one source; upper outputs stay off
    for (k = 1; k < 6; k++)
    begin
      sel = 9'(k);
      src = 5'(1 << (k - 1));
      tick(3);
      check(12'(sw), 12'h1);
      src = ~src;
      tick(3);
      check(12'(sw), 12'h0);
    end
    // timed 0.25 s mode: 250 ms of 10 cycles each, so 2500 cycles after the source drops
    mode = 3'h0;
    sel = 9'h001;
    src = 5'h01;
    tick(2);
    src = 5'h0;
    tick(2400);
    check(12'(sw), 12'h1);
    tick(200);
    check(12'(sw), 12'h0);
    mode = 3'h5;
    sel = 9'h001;
    src = 5'h01;
    tick(2);
    src = 5'h0;
    tick(3);
    check(12'(sw), 12'h1);
    strobe(3'h4, 4'h3);
    tick(6);
    check(12'(sw), 12'h0);
    $display("alarm test done");
    // amplitude at 100 percent, thickness below display start, thickness at full range
    for (k = 0; k < 3; k++)
    begin
      isThk = (k != 0);
      dStart = (k == 2) ? 12'h000 : 12'h100;
      thk = (k == 2) ? 12'h200 : 12'h010;
      intStart = 1'b1;
      tick(1);
      intStart = 1'b0;
      wait_tto;
      check(12'(tto), 12'h1);
      check(12'(dv), 12'h1);
      done = 1'b1;
      tick(1);
      done = 1'b0;
      check(12'(dv), 12'h0);
      check(ao, (k == 1) ? 12'h000 : 12'hfff);
      tick(TC);
    end
    $display("analog test done");
    spike = 1'b1;
    extSrc = 1'b1;
    strobe(3'h1, 4'h1);
    tick(8);
    check(12'(tto), 12'h0);
    strobe(3'h1, 4'h3);
    wait_tto;
    check(12'(tto), 12'h1);
    c = 0;
    while (fire !== 1'b1 && c < 100)
    begin
      tick(1);
      c++;
    end
    check(12'(c), 12'(FC));
    tick(TC - FC - 1);
    check(12'(tto), 12'h1);
    tick(1);
    check(12'(tto), 12'h0);
    spike = 1'b0;
    tick(2);
    strobe(3'h1, 4'h3);
    tick(8);
    check(12'(tto), 12'h0);
    $display("trigger test done");
    give_verdict;
  end
endmodule : test_test_cycle_io_port
